// ===== hdl/dbs_consts.svh
`ifndef DBS_CONSTS_SVH
`define DBS_CONSTS_SVH

// =====================================================================
// Widths of the pin groups (x18 ball map)
`define DBS_ADDR_W 20
`define DBS_BUS_W 36
`define DBS_USED_W 18
`define DBS_LANES 2
`define DBS_LANE_W 9
`define DBS_MEM_AW 22

// =====================================================================
// Burst and latency, counted in input clock half-cycle edges
`define DBS_BURST 4
`define DBS_SCHED_D 8
`define DBS_RD_LAT_DLL 5
`define DBS_RD_LAT_BYP 2 // Loop off: one full cycle, first beat on a true edge
`define DBS_WR_LAT 2

// =====================================================================
// Loop lock time, counted in true input clock periods
`define DBS_LOCK_W 12
`define DBS_LOCK_CYC 12'h800

`endif

// ===== hdl/dbs_pkg.sv
`include "dbs_consts.svh"

package dbs_pkg;

    // =================================================================
    // One half-cycle slot of the burst schedule
    typedef struct packed {
        logic valid;
        logic wr;
        logic [`DBS_ADDR_W-1:0] addr;
        logic [1:0] beat;
    } dbs_slot_t;

    // =================================================================
    // Delay-locked loop modes
    typedef enum logic [2:0] {
        DBS_BYPASS = 3'b001,
        DBS_LOCKING = 3'b010,
        DBS_LOCKED = 3'b100
    } dbs_dll_t;

    // =================================================================
    // State of the port apart from the memory array
    typedef struct packed {
        logic [3:0] k_pipe;
        logic [3:0] kn_pipe;
        logic [1:0] ld_n_s;
        logic [1:0] rw_s;
        logic [1:0] off_n_s;
        logic [`DBS_ADDR_W-1:0] addr_s1;
        logic [`DBS_ADDR_W-1:0] addr_s2;
        logic [`DBS_USED_W-1:0] dq_s1;
        logic [`DBS_USED_W-1:0] dq_s2;
        logic [`DBS_LANES-1:0] bw_n_s1;
        logic [`DBS_LANES-1:0] bw_n_s2;
        dbs_slot_t [`DBS_SCHED_D-1:0] sched;
        dbs_dll_t mode;
        logic [`DBS_LOCK_W-1:0] lock_cnt;
        logic rd_go;
        logic edge_seen;
        logic drive;
        logic [`DBS_USED_W-1:0] dq_out;
    } dbs_state_t;

endpackage

// ===== hdl/dbs_mem.sv
`timescale 1ns/1ns
`include "dbs_consts.svh"

module dbs_mem
(
    // Clock
    input wire logic clk_i,
    // Read port
    input wire logic rd_en_i,
    input wire logic [`DBS_MEM_AW-1:0] rd_addr_i,
    output logic [`DBS_USED_W-1:0] rd_data_o,
    // Write port with byte lanes
    input wire logic wr_en_i,
    input wire logic [`DBS_LANES-1:0] wr_be_i,
    input wire logic [`DBS_MEM_AW-1:0] wr_addr_i,
    input wire logic [`DBS_USED_W-1:0] wr_data_i
);

    // =================================================================
    // Storage array
    logic [`DBS_USED_W-1:0] mem [0:(1<<`DBS_MEM_AW)-1];
    logic [`DBS_USED_W-1:0] rd_data_q;

    // Lane-wise write, registered read
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < `DBS_LANES; i++)
        begin
            if (wr_en_i && wr_be_i[i])
            begin
                mem[wr_addr_i][i*`DBS_LANE_W +: `DBS_LANE_W] <=
                    wr_data_i[i*`DBS_LANE_W +: `DBS_LANE_W];
            end
        end
        if (rd_en_i)
        begin
            rd_data_q <= mem[rd_addr_i];
        end
    end

    assign rd_data_o = rd_data_q;

endmodule

// ===== hdl/dbs_port.sv
`timescale 1ns/1ns
`include "dbs_consts.svh"


module dbs_port
(
    // Core clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Input clock pair from the controller
    input wire logic clock_true_i,
    input wire logic clock_comp_i,
    // Command pins
    input wire logic load_strobe_n_i,
    input wire logic read_write_i,
    input wire logic [`DBS_ADDR_W-1:0] sync_address_bus_i,
    input wire logic [`DBS_LANES-1:0] byte_write_n_i,
    input wire logic loop_disable_n_i,
    // Two-way data bus
    input wire logic [`DBS_BUS_W-1:0] data_io_bus_i,
    output logic [`DBS_BUS_W-1:0] data_io_bus_o,
    output logic [`DBS_BUS_W-1:0] data_io_bus_oe_n_o,
    // Echo clocks and status
    output logic echo_clock_true_o,
    output logic echo_clock_comp_o,
    output logic output_valid_flag_o,
    output logic loop_locked_o
);

    // =================================================================
    // Shared helpers
    function automatic logic rise(input logic [3:0] pipe);
        rise = pipe[1] & ~pipe[2];
    endfunction

    function automatic dbs_pkg::dbs_slot_t mk_slot(input logic wr,
        input logic [`DBS_ADDR_W-1:0] addr, input logic [1:0] beat);
        mk_slot.valid = 1'b1;
        mk_slot.wr = wr;
        mk_slot.addr = addr;
        mk_slot.beat = beat;
    endfunction

    // =================================================================
    // State and memory wiring
    dbs_pkg::dbs_state_t s_q;
    dbs_pkg::dbs_state_t s_d;
    logic k_rise;
    logic kn_rise;
    logic any_edge;
    dbs_pkg::dbs_slot_t cur;
    logic mem_rd;
    logic mem_wr;
    logic [`DBS_MEM_AW-1:0] mem_addr;
    logic [`DBS_USED_W-1:0] mem_rdata;

    // Edges of the sampled clock pair, seen after two flops
    assign k_rise = rise(s_q.k_pipe);
    assign kn_rise = rise(s_q.kn_pipe);
    assign any_edge = k_rise | kn_rise;
    assign cur = s_q.sched[0];

    // Slot at the head of the schedule acts on the current edge
    assign mem_rd = any_edge & cur.valid & ~cur.wr;
    assign mem_wr = any_edge & cur.valid & cur.wr;
    assign mem_addr = {cur.addr, cur.beat};

    // =================================================================
    // Next-state logic
    always_comb
    begin
        logic [2:0] lat;
        lat = 3'h0;
        s_d = s_q;

        // Two-flop synchronisers; echo taps sit two flops further on
        s_d.k_pipe = {s_q.k_pipe[2:0], clock_true_i};
        s_d.kn_pipe = {s_q.kn_pipe[2:0], clock_comp_i};
        s_d.ld_n_s = {s_q.ld_n_s[0], load_strobe_n_i};
        s_d.rw_s = {s_q.rw_s[0], read_write_i};
        s_d.off_n_s = {s_q.off_n_s[0], loop_disable_n_i};
        s_d.addr_s1 = sync_address_bus_i;
        s_d.addr_s2 = s_q.addr_s1;
        s_d.dq_s1 = data_io_bus_i[`DBS_USED_W-1:0];
        s_d.dq_s2 = s_q.dq_s1;
        s_d.bw_n_s1 = byte_write_n_i;
        s_d.bw_n_s2 = s_q.bw_n_s1;

        // Loop mode: low input bypasses and forgets, high runs to lock
        if (!s_q.off_n_s[1])
        begin
            s_d.mode = dbs_pkg::DBS_BYPASS;
            s_d.lock_cnt = '0;
        end
        else
        begin
            unique case (s_q.mode)
                dbs_pkg::DBS_BYPASS:
                begin
                    s_d.mode = dbs_pkg::DBS_LOCKING;
                end
                dbs_pkg::DBS_LOCKING:
                begin
                    if (k_rise)
                    begin
                        s_d.lock_cnt = s_q.lock_cnt + 12'h001;
                        if (s_q.lock_cnt == `DBS_LOCK_CYC - 12'h001)
                        begin
                            s_d.mode = dbs_pkg::DBS_LOCKED;
                        end
                    end
                end
                dbs_pkg::DBS_LOCKED:
                begin
                    s_d.mode = dbs_pkg::DBS_LOCKED;
                end
                default:
                begin
                    s_d.mode = dbs_pkg::DBS_BYPASS;
                end
            endcase
        end

        // Advance the schedule one slot per half-cycle edge
        if (any_edge)
        begin
            for (int i = 0; i < `DBS_SCHED_D - 1; i++)
            begin
                s_d.sched[i] = s_q.sched[i+1];
            end
            s_d.sched[`DBS_SCHED_D-1] = '0;
        end

        // New access only on a true edge with load low
        if (k_rise && !s_q.ld_n_s[1])
        begin
            if (s_q.rw_s[1])
            begin
                lat = (s_q.mode == dbs_pkg::DBS_BYPASS) ? 3'(`DBS_RD_LAT_BYP)
                    : 3'(`DBS_RD_LAT_DLL);
            end
            else
            begin
                lat = 3'(`DBS_WR_LAT);
            end
            for (int b = 0; b < `DBS_BURST; b++)
            begin
                s_d.sched[lat - 3'h1 + 3'(b)] = mk_slot(~s_q.rw_s[1], s_q.addr_s2,
                    2'(b));
            end
        end

        // Read data leaves the memory register one cycle after the edge
        s_d.rd_go = mem_rd;
        s_d.edge_seen = any_edge;
        if (s_q.rd_go)
        begin
            s_d.drive = 1'b1;
            s_d.dq_out = mem_rdata;
        end
        else if (s_q.edge_seen)
        begin
            s_d.drive = 1'b0;
        end
    end

    // =================================================================
    // State register
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
            s_q.mode <= dbs_pkg::DBS_BYPASS;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // =================================================================
    // Array with byte-lane writes
    dbs_mem u_mem
    (
        .clk_i(core_clk_i),
        .rd_en_i(mem_rd),
        .rd_addr_i(mem_addr),
        .rd_data_o(mem_rdata),
        .wr_en_i(mem_wr),
        .wr_be_i(~s_q.bw_n_s2),
        .wr_addr_i(mem_addr),
        .wr_data_i(s_q.dq_s2)
    );

    // =================================================================
    // Pin outputs; echo taps share the data path delay so they line up
    assign echo_clock_true_o = s_q.k_pipe[3];
    assign echo_clock_comp_o = s_q.kn_pipe[3];
    assign output_valid_flag_o = s_q.drive;
    assign data_io_bus_o = {{(`DBS_BUS_W-`DBS_USED_W){1'b0}}, s_q.dq_out};
    assign data_io_bus_oe_n_o = {{(`DBS_BUS_W-`DBS_USED_W){1'b1}},
        {`DBS_USED_W{~s_q.drive}}};
    assign loop_locked_o = (s_q.mode == dbs_pkg::DBS_LOCKED);

endmodule

// ===== tb/dbs_port_chk.sv
`timescale 1ns/1ns
`include "dbs_consts.svh"

// =====================================================================
// Port checker; cycle figures assume the 400 ns bench input clock
module dbs_port_chk
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Watched pins
    input wire logic loop_disable_n_i,
    input wire logic [`DBS_BUS_W-1:0] data_io_bus_o,
    input wire logic [`DBS_BUS_W-1:0] data_io_bus_oe_n_o,
    input wire logic echo_clock_true_o,
    input wire logic echo_clock_comp_o,
    input wire logic output_valid_flag_o,
    input wire logic loop_locked_o
);
    logic [3:0] up_q;
    logic [3:0] idle_q;
    logic echo_q;
    logic [4:0] hi_q;
    logic [15:0] on_q;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // Run lengths; the echo pipe is given 15 cycles to fill after reset
    always_ff @(posedge core_clk_i)
    begin
        up_q <= rst_i ? 4'h0 : up_q + {3'h0, up_q != 4'hf};
        idle_q <= (echo_clock_true_o != echo_q) ? 4'h0 : idle_q + {3'h0, idle_q != 4'hf};
        echo_q <= echo_clock_true_o;
        hi_q <= output_valid_flag_o ? hi_q + 5'h1 : 5'h0;
        on_q <= (loop_disable_n_i && !rst_i) ? on_q + 16'h1 : 16'h0;
    end

    // =================================================================
    // Assertions
    AST_UNUSED_LINES: assert property (data_io_bus_o[35:18] == 18'h0 &&
        data_io_bus_oe_n_o[35:18] == 18'h3ffff) else $error("upper lines active");
    AST_ECHO_RUNS: assert property (up_q == 4'hf |-> idle_q < 4'h5)
        else $error("echo clock stopped");
    AST_ECHO_ANTI: assert property (up_q == 4'hf |-> echo_clock_true_o != echo_clock_comp_o)
        else $error("echo pair not complementary");
    AST_DATA_ECHO: assert property ($changed(data_io_bus_o[17:0]) |->
        $changed(echo_clock_true_o)) else $error("data moved off echo edge");
    AST_VALID_ECHO: assert property ($changed(output_valid_flag_o) |->
        $changed(echo_clock_true_o)) else $error("valid moved off echo edge");
    AST_VALID_OE: assert property (data_io_bus_oe_n_o[17:0] == {18{!output_valid_flag_o}})
        else $error("enable and valid disagree");
    AST_BURST_FOUR: assert property ($fell(output_valid_flag_o) |-> hi_q == 5'h10)
        else $error("read burst not four beats");
    AST_BYPASS: assert property (!loop_disable_n_i [*4] |-> !loop_locked_o)
        else $error("locked while bypassed");
    AST_LOCK_TIME: assert property ($rose(loop_locked_o) |-> on_q >= 16'h3ff0 &&
        on_q <= 16'h4010) else $error("lock time wrong");
endmodule

bind dbs_port dbs_port_chk chk_u
(
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .loop_disable_n_i(loop_disable_n_i),
    .data_io_bus_o(data_io_bus_o),
    .data_io_bus_oe_n_o(data_io_bus_oe_n_o),
    .echo_clock_true_o(echo_clock_true_o),
    .echo_clock_comp_o(echo_clock_comp_o),
    .output_valid_flag_o(output_valid_flag_o),
    .loop_locked_o(loop_locked_o)
);

// ===== tb/dbs_ctl_model.sv
`timescale 1ns/1ns
`include "dbs_consts.svh"

// =====================================================================
// Memory controller model
module dbs_ctl_model
(
    // Pacing clock
    input wire logic core_clk_i,
    // Pins toward the port
    output logic clock_true_o,
    output logic clock_comp_o,
    output logic load_strobe_n_o = 1'b1,
    output logic read_write_o = 1'b0,
    output logic [`DBS_ADDR_W-1:0] addr_o = 20'h0,
    output logic [`DBS_LANES-1:0] byte_write_n_o = 2'h3,
    output logic [`DBS_USED_W-1:0] dq_o = 18'h0
);
    time t_cmd;

    // Free-running clock pair, phase unrelated to the core clock
    initial
    begin
        clock_true_o = 1'b0;
        #13;
        forever #200 clock_true_o = ~clock_true_o;
    end
    assign clock_comp_o = ~clock_true_o;

    // Pins move two core clock cycles after each input clock edge, clear of both
    task automatic step();
        @(clock_true_o);
        repeat (2) @(posedge core_clk_i);
    endtask

    task automatic xfer(input logic rd, input logic [19:0] a, input logic [71:0] d,
        input logic [7:0] bwn);
        @(negedge clock_true_o);
        repeat (2) @(posedge core_clk_i);
        load_strobe_n_o <= 1'b0;
        read_write_o <= rd;
        addr_o <= a;
        @(clock_true_o);
        t_cmd = $time;
        repeat (2) @(posedge core_clk_i);
        step();
        load_strobe_n_o <= 1'b1;
        addr_o <= ~a;
        for (int i = 0; i < 4; i++)
        begin
            dq_o <= rd ? ~dq_o : d[18*i +: 18];
            byte_write_n_o <= rd ? 2'h3 : bwn[2*i +: 2];
            step();
        end
        // Released bus shows no stale value
        dq_o <= ~dq_o;
        repeat (6) step();
    endtask
endmodule

// ===== tb/ddr_burst4_cio_sram_port_tb.sv
`timescale 1ns/1ns
`include "dbs_consts.svh"

`define CHECK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH at %0t: got %h want %h", $time, g, e); end end

module ddr_burst4_cio_sram_port_tb;
    typedef struct packed {logic rd; logic [19:0] a; logic [71:0] d; logic [7:0] bwn;} dbs_row_t;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic loop_disable_n_i = 1'b1;
    logic ct, cc, ld_n, rw, echo_t, echo_c, valid, locked, echo_prev;
    logic [19:0] addr;
    logic [1:0] bw_n;
    logic [17:0] mdq;
    logic [35:0] bus_o, oe_n;
    logic [71:0] rd_q;
    int n_beats, err_count, check_count;
    time t_first;
    dbs_row_t rows [5] = '{
        '{1'b0, 20'h00010, 72'h5ac3c30f0fa5a59669, 8'h00},
        '{1'b1, 20'h00010, 72'h5ac3c30f0fa5a59669, 8'h00},
        '{1'b0, 20'h00020, 72'h0, 8'h00},
        '{1'b0, 20'h00020, {72{1'b1}}, 8'h11},
        '{1'b1, 20'h00020, {18'h3ffff, 18'h3fe00, 18'h3ffff, 18'h3fe00}, 8'h00}};

    dbs_ctl_model ctl_u (.core_clk_i(core_clk_i), .clock_true_o(ct), .clock_comp_o(cc),
        .load_strobe_n_o(ld_n), .read_write_o(rw), .addr_o(addr), .byte_write_n_o(bw_n),
        .dq_o(mdq));
    dbs_port dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .clock_true_i(ct),
        .clock_comp_i(cc), .load_strobe_n_i(ld_n), .read_write_i(rw),
        .sync_address_bus_i(addr), .byte_write_n_i(bw_n), .loop_disable_n_i(loop_disable_n_i),
        .data_io_bus_i({18'h0, (bus_o[17:0] & ~oe_n[17:0]) | (mdq & oe_n[17:0])}),
        .data_io_bus_o(bus_o), .data_io_bus_oe_n_o(oe_n), .echo_clock_true_o(echo_t),
        .echo_clock_comp_o(echo_c), .output_valid_flag_o(valid), .loop_locked_o(locked));

    // Clock and watchdog
    initial forever #25 core_clk_i = ~core_clk_i;
    initial
    begin
        #2000000;
        err_count++;
        give_verdict();
    end

    // Read beats are taken on each echo edge while valid is up
    always @(negedge core_clk_i)
    begin
        if (echo_t !== echo_prev && valid === 1'b1)
        begin
            if (n_beats == 0) t_first = $time;
            rd_q[18*n_beats +: 18] = bus_o[17:0];
            n_beats++;
        end
        echo_prev = echo_t;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic run_row(input dbs_row_t r, input int half);
        time lat;
        n_beats = 0;
        ctl_u.xfer(r.rd, r.a, r.d, r.bwn);
        lat = t_first - ctl_u.t_cmd;
        if (r.rd)
        begin
            `CHECK(n_beats, 4)
            `CHECK(rd_q, r.d)
            // Sync, memory and output flops add 3 to 4 core cycles, then a half-cycle sample
            `CHECK(lat > half * 200 + 150 && lat < half * 200 + 250, 1'b1)
        end
    endtask

    // =================================================================
    // Main sequence
    initial
    begin
        repeat (2) @(posedge core_clk_i);
        `CHECK({bus_o, oe_n, valid, locked}, {36'h0, {36{1'b1}}, 2'b0})
        rst_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        foreach (rows[i]) run_row(rows[i], 5);
        for (int i = 0; i < 17000 && locked !== 1'b1; i++) @(posedge core_clk_i);
        `CHECK(locked, 1'b1)
        run_row(rows[1], 5);
        loop_disable_n_i <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        `CHECK(locked, 1'b0)
        run_row(rows[4], 2);
        loop_disable_n_i <= 1'b1;
        repeat (200) @(posedge core_clk_i);
        `CHECK(locked, 1'b0)
        give_verdict();
    end
endmodule
